// *** verilog/dsp_ctl_pkg.sv ***
// shared constants and types for the processor control and reset logic
package dsp_ctl_pkg;
    localparam int unsigned   CLK_HZ         = 20_000_000;  // master clock rate
    localparam int unsigned   CLK_DIV        = 4;           // system clock is master clock over four
    localparam int unsigned   PHASE_W        = 2;           // phase counter width
    localparam logic [1:0]    PHASE_LAST     = 2'h3;        // last master cycle of an internal cycle
    localparam logic [1:0]    PHASE_HIGH_END = 2'h1;        // system clock high on phases 0 and 1
    localparam logic [1:0]    PHASE_DATA     = 2'h3;        // read data captured on this phase
    localparam int unsigned   ADDR_W         = 12;          // external address lines
    localparam int unsigned   DATA_W         = 16;          // data lines
    localparam int unsigned   PORT_W         = 3;           // port number lines
    localparam int unsigned   SYNC_STAGES    = 2;           // synchroniser depth
    localparam logic [1:0]    CLEAR_TICKS    = 2'h2;        // boundaries until address clear
    localparam logic [1:0]    EXIT_TICKS     = 2'h2;        // boundaries until execution resumes
    localparam int unsigned   RESET_MIN_CYC  = 5;           // least reset length, internal cycles
    localparam logic [11:0]   ADDR_RST       = 12'h000;     // cleared address and counter

    // external access kinds
    typedef enum logic [2:0]
    {
        OP_NONE     = 3'h0,
        OP_FETCH    = 3'h1,
        OP_READ     = 3'h2,
        OP_WRITE    = 3'h3,
        OP_PORT_IN  = 3'h4,
        OP_PORT_OUT = 3'h5
    } op_t;

    // reset sequencer, gray along run, hold, cleared, exit
    typedef enum logic [1:0]
    {
        ST_RUN     = 2'h0,
        ST_HOLD    = 2'h1,
        ST_CLEARED = 2'h3,
        ST_EXIT    = 2'h2
    } seq_state_t;
endpackage : dsp_ctl_pkg

// *** verilog/phase_if.sv ***
// internal cycle phase shared between the divider and the controller
`timescale 1ns/10ps
interface phase_if;
    logic [1:0] phase;    // master cycle within the internal cycle
    logic       tick;     // high on the last master cycle
    logic       sys_clk;  // registered system clock level

    modport src (output phase, output tick, output sys_clk);
    modport dst (input phase, input tick, input sys_clk);
endinterface : phase_if

// *** verilog/sync_stage.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync_stage #(
    parameter int unsigned      WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;       // first stage, read only by q
    logic [WIDTH-1:0] next_meta;  // next first stage
    logic [WIDTH-1:0] next_q;     // next second stage

    // next values
    always_comb
    begin
        next_meta = d;
        next_q    = meta;
    end

    // both stages reset to a constant
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule : sync_stage

// *** verilog/clk_divider.sv ***
// divides the master clock by four into the system clock and phases
`timescale 1ns/10ps
module clk_divider
    import dsp_ctl_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    phase_if.src      ph
);
    logic [1:0] next_phase;  // next phase count
    logic       next_tick;   // next last-phase flag
    logic       next_clk;    // next system clock level

    // free running; the reset pin never stops the divider, only srst holds it at the last phase
    always_comb
    begin
        next_phase = ph.phase + 2'h1;
        next_tick  = (next_phase == PHASE_LAST);
        next_clk   = (next_phase <= PHASE_HIGH_END);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ph.phase   <= PHASE_LAST;
            ph.tick    <= 1'b1;
            ph.sys_clk <= 1'b0;
        end
        else
        begin
            ph.phase   <= next_phase;
            ph.tick    <= next_tick;
            ph.sys_clk <= next_clk;
        end
    end
endmodule : clk_divider

// *** verilog/dsp_reset_and_control_inputs.sv ***
// reset sequencing, bus strobes and control inputs of the processor
//
// Contract
// - reset forces strobes high, data bus off
// - address and counter cleared after full cycle
// - execution resumes one full cycle after release
// - reset pin synchronised; latency fixed, same at any phase
// - at most one strobe active at once
// - reset accepted anywhere within a cycle
// - system clock is quarter master clock
// - mode select high on-chip, low external
// - port number on lowest three address lines
// - read strobe only while accepting input
// - fetch strobe while expecting external instruction
// - write strobe only while driving data
// - branch on poll samples poll input
`timescale 1ns/10ps
module dsp_reset_and_control_inputs
    import dsp_ctl_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           srst,
    input  wire logic                           reset_in_n,
    input  wire logic                           memory_config_select,
    input  wire logic                           branch_poll_in_n,
    input  wire logic                           interrupt_in_n,
    output logic                                system_clock_out,
    output logic                                data_read_strobe_n,
    output logic                                write_strobe_n,
    output logic                                instr_fetch_strobe_n,
    output logic [dsp_ctl_pkg::ADDR_W-1:0]      address_lines,
    input  wire logic [dsp_ctl_pkg::DATA_W-1:0] data_lines_in,
    output logic [dsp_ctl_pkg::DATA_W-1:0]      data_lines_out,
    output logic                                data_lines_oe,
    input  wire logic                           cmd_valid,
    input  wire dsp_ctl_pkg::op_t               cmd_op,
    input  wire logic [dsp_ctl_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [dsp_ctl_pkg::DATA_W-1:0] cmd_wdata,
    output logic                                cmd_ready,
    output logic [dsp_ctl_pkg::DATA_W-1:0]      rdata,
    output logic                                rdata_valid,
    output logic                                onchip_fetch,
    input  wire logic                           branch_on_poll_low_instr,
    input  wire logic [dsp_ctl_pkg::ADDR_W-1:0] branch_target,
    output logic                                branch_taken,
    output logic [dsp_ctl_pkg::ADDR_W-1:0]      program_counter,
    output logic                                interrupt_req
);
    import dsp_ctl_pkg::*;

    phase_if ph ();                           // phase from the divider

    logic              rst_pin_s;             // synchronised reset pin, active low
    logic              mode_s;                // synchronised mode select
    logic              poll_s_n;              // synchronised poll pin
    logic              intr_s_n;              // synchronised interrupt pin
    logic [DATA_W-1:0] data_s;                // synchronised data bus
    logic              rst_s;                 // reset requested, active high

    seq_state_t        state;                 // reset sequencer state
    seq_state_t        next_state;
    logic [1:0]        ticks;                 // cycle boundaries seen in state
    logic [1:0]        next_ticks;
    op_t               cur_op;                // access of this internal cycle
    op_t               next_cur_op;
    logic [DATA_W-1:0] wdata;                 // held write data
    logic [DATA_W-1:0] next_wdata;

    logic              next_read_n;           // next output values
    logic              next_write_n;
    logic              next_fetch_n;
    logic [ADDR_W-1:0] next_address;
    logic [DATA_W-1:0] next_data_out;
    logic              next_data_oe;
    logic              next_ready;
    logic [DATA_W-1:0] next_rdata;
    logic              next_rdata_valid;
    logic              next_onchip;
    logic              next_taken;
    logic [ADDR_W-1:0] next_pc;
    logic              next_intr;
    logic              accept;                // request taken this cycle
    logic              leave_exit;            // last master cycle before resume
    logic              early;                 // strobe window, phases 1 and 2 next
    logic              ext_fetch;             // fetch goes to external memory

    clk_divider u_div
    (
        .clk  (clk),
        .srst (srst),
        .ph   (ph)
    );

    // reset pin through two flops before any logic reads it
    // level sampled every master edge, so any arrival point works
    sync_stage #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_rst
    (
        .clk  (clk),
        .srst (srst),
        .d    (reset_in_n),
        .q    (rst_pin_s)
    );

    // mode, poll and interrupt pins; inactive levels at reset
    sync_stage #(.WIDTH(3), .RST_VAL(3'h3)) u_sync_ctl
    (
        .clk  (clk),
        .srst (srst),
        .d    ({memory_config_select, branch_poll_in_n, interrupt_in_n}),
        .q    ({mode_s, poll_s_n, intr_s_n})
    );

    // data bus samples; capture waits for the settled copy
    sync_stage #(.WIDTH(DATA_W), .RST_VAL('0)) u_sync_data
    (
        .clk  (clk),
        .srst (srst),
        .d    (data_lines_in),
        .q    (data_s)
    );

    assign rst_s            = ~rst_pin_s;
    assign system_clock_out = ph.sys_clk;

    // reset sequencer: counts internal cycle boundaries in hold and exit
    always_comb
    begin
        next_state = state;
        next_ticks = ticks;
        leave_exit = 1'b0;
        case (state)
            ST_RUN:
            begin
                if (rst_s)
                begin
                    next_state = ST_HOLD;
                    next_ticks = 2'h0;
                end
            end
            ST_HOLD:
            begin
                if (!rst_s)
                begin
                    // release before the clear; still resumes cleanly
                    next_state = ST_EXIT;
                    next_ticks = 2'h0;
                end
                else if (ph.tick)
                begin
                    next_ticks = ticks + 2'h1;
                    // clear after first full internal cycle
                    if (next_ticks == CLEAR_TICKS)
                    begin
                        next_state = ST_CLEARED;
                    end
                end
            end
            ST_CLEARED:
            begin
                if (!rst_s)
                begin
                    next_state = ST_EXIT;
                    next_ticks = 2'h0;
                end
            end
            ST_EXIT:
            begin
                if (rst_s)
                begin
                    next_state = ST_HOLD;
                    next_ticks = 2'h0;
                end
                else if (ph.tick)
                begin
                    next_ticks = ticks + 2'h1;
                    // resume after one complete internal cycle
                    if (next_ticks == EXIT_TICKS)
                    begin
                        next_state = ST_RUN;
                        leave_exit = 1'b1;
                    end
                end
            end
            default:
            begin
                next_state = ST_HOLD;
                next_ticks = 2'h0;
            end
        endcase
    end

    // access engine and pin outputs
    always_comb
    begin
        // requests only taken on a boundary into a running cycle
        accept    = cmd_valid && cmd_ready && ph.tick && !rst_s && (state == ST_RUN);
        ext_fetch = !mode_s;
        early     = (ph.phase == 2'h0) || (ph.phase == 2'h1);

        next_cur_op      = cur_op;
        next_wdata       = wdata;
        next_address     = address_lines;
        next_pc          = program_counter;
        next_rdata       = rdata;
        next_rdata_valid = 1'b0;
        next_onchip      = 1'b0;
        next_taken       = 1'b0;
        next_ready       = (next_state == ST_RUN);
        next_intr        = !intr_s_n;

        if (ph.tick)
        begin
            next_cur_op = accept ? cmd_op : OP_NONE;
            if (accept)
            begin
                next_wdata = cmd_wdata;
                case (cmd_op)
                    OP_FETCH:
                    begin
                        next_address = program_counter;
                        next_pc      = program_counter + 12'h001;
                        next_onchip  = !ext_fetch;
                    end
                    OP_READ,
                    OP_WRITE:
                    begin
                        next_address = cmd_addr;
                    end
                    // port number on the low lines, rest zero
                    OP_PORT_IN,
                    OP_PORT_OUT:
                    begin
                        next_address = {{(ADDR_W-PORT_W){1'b0}}, cmd_addr[PORT_W-1:0]};
                    end
                    default:
                    begin
                        next_address = address_lines;
                    end
                endcase
            end
        end

        // poll level picks the jump; fetch counter advance loses
        if (branch_on_poll_low_instr && (state == ST_RUN) && !rst_s)
        begin
            next_taken = !poll_s_n;
            if (!poll_s_n)
            begin
                next_pc = branch_target;
            end
        end

        // capture input data at the end of a reading cycle
        if ((state == ST_RUN) && (ph.phase == PHASE_DATA))
        begin
            if ((cur_op == OP_READ) || (cur_op == OP_PORT_IN) ||
                ((cur_op == OP_FETCH) && ext_fetch))
            begin
                next_rdata       = data_s;
                next_rdata_valid = 1'b1;
            end
        end

        // read strobe only for data and port input
        next_read_n   = !(early && !rst_s && (state == ST_RUN) &&
                          ((cur_op == OP_READ) || (cur_op == OP_PORT_IN)));
        // fetch strobe only in external program mode
        next_fetch_n  = !(early && !rst_s && (state == ST_RUN) &&
                          (cur_op == OP_FETCH) && ext_fetch);
        // write strobe inside the window the bus is driven
        next_write_n  = !(early && !rst_s && (state == ST_RUN) &&
                          ((cur_op == OP_WRITE) || (cur_op == OP_PORT_OUT)));
        // bus driven phases 1 to 3 so data starts with the strobe and trails it by one phase
        next_data_oe  = (ph.phase != PHASE_LAST) && !rst_s && (state == ST_RUN) &&
                        ((cur_op == OP_WRITE) || (cur_op == OP_PORT_OUT));
        next_data_out = wdata;

        // reset forces strobes inactive and the bus off
        if (rst_s || (state != ST_RUN))
        begin
            next_cur_op = leave_exit ? next_cur_op : OP_NONE;
            next_rdata_valid = 1'b0;
            next_onchip = 1'b0;
        end

        // clear address and counter; again on resume for early release
        // a write cut by reset may leave a bad address, by design
        if ((next_state == ST_CLEARED && state == ST_HOLD) || leave_exit)
        begin
            next_address = ADDR_RST;
            next_pc      = ADDR_RST;
        end

        // no access starts on this boundary; the first access of the resumed run waits for the next one
        if (leave_exit)
        begin
            next_cur_op = OP_NONE;
        end
    end

    // all state and outputs registered
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state                <= ST_HOLD;
            ticks                <= 2'h0;
            cur_op               <= OP_NONE;
            wdata                <= '0;
            data_read_strobe_n   <= 1'b1;
            write_strobe_n       <= 1'b1;
            instr_fetch_strobe_n <= 1'b1;
            address_lines        <= ADDR_RST;
            data_lines_out       <= '0;
            data_lines_oe        <= 1'b0;
            cmd_ready            <= 1'b0;
            rdata                <= '0;
            rdata_valid          <= 1'b0;
            onchip_fetch         <= 1'b0;
            branch_taken         <= 1'b0;
            program_counter      <= ADDR_RST;
            interrupt_req        <= 1'b0;
        end
        else
        begin
            state                <= next_state;
            ticks                <= next_ticks;
            cur_op               <= next_cur_op;
            wdata                <= next_wdata;
            data_read_strobe_n   <= next_read_n;
            write_strobe_n       <= next_write_n;
            instr_fetch_strobe_n <= next_fetch_n;
            address_lines        <= next_address;
            data_lines_out       <= next_data_out;
            data_lines_oe        <= next_data_oe;
            cmd_ready            <= next_ready;
            rdata                <= next_rdata;
            rdata_valid          <= next_rdata_valid;
            onchip_fetch         <= next_onchip;
            branch_taken         <= next_taken;
            program_counter      <= next_pc;
            interrupt_req        <= next_intr;
        end
    end

    // checks on the driven pins
    sequence s_clk_period;
        system_clock_out [*2] ##1 !system_clock_out [*2] ##1 system_clock_out;
    endsequence

    sequence s_released;
        ##[1:10] (cmd_ready && state == ST_RUN);
    endsequence

    property p_reset_forces;
        @(posedge clk) disable iff (srst)
        rst_s |=> (data_read_strobe_n && write_strobe_n && instr_fetch_strobe_n && !data_lines_oe);
    endproperty
    a_reset_forces: assert property (p_reset_forces) else $error("strobe or bus active in reset");

    property p_clear;
        @(posedge clk) disable iff (srst)
        (state == ST_HOLD && rst_s) ##1 (state == ST_CLEARED) |->
            (address_lines == ADDR_RST && program_counter == ADDR_RST);
    endproperty
    a_clear: assert property (p_clear) else $error("address not cleared in reset");

    property p_resume;
        @(posedge clk) disable iff (srst)
        (state == ST_CLEARED && !rst_s) |-> s_released;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after release");

    property p_sync_entry;
        @(posedge clk) disable iff (srst)
        ($fell(reset_in_n) && state == ST_RUN) |-> ##[1:3] (state == ST_HOLD);
    endproperty
    a_sync_entry: assert property (p_sync_entry) else $error("reset entry latency wrong");

    property p_onehot;
        @(posedge clk) disable iff (srst)
        $onehot0({!data_read_strobe_n, !write_strobe_n, !instr_fetch_strobe_n});
    endproperty
    a_onehot: assert property (p_onehot) else $error("two strobes active");

    property p_sys_clk;
        @(posedge clk) disable iff (srst)
        $rose(system_clock_out) |-> s_clk_period;
    endproperty
    a_sys_clk: assert property (p_sys_clk) else $error("system clock not quarter rate");

    property p_fetch_mode;
        @(posedge clk) disable iff (srst)
        !instr_fetch_strobe_n |-> !$past(mode_s);
    endproperty
    a_fetch_mode: assert property (p_fetch_mode) else $error("fetch strobe in on-chip mode");

    property p_port_addr;
        @(posedge clk) disable iff (srst)
        (ph.phase == 2'h1 && (cur_op == OP_PORT_IN || cur_op == OP_PORT_OUT))
            |-> (address_lines[ADDR_W-1:PORT_W] == '0);
    endproperty
    a_port_addr: assert property (p_port_addr) else $error("port address above low lines");

    property p_read_bus;
        @(posedge clk) disable iff (srst)
        !data_read_strobe_n |-> (!data_lines_oe && (cur_op == OP_READ || cur_op == OP_PORT_IN) ##1 !data_lines_oe);
    endproperty
    a_read_bus: assert property (p_read_bus) else $error("bus driven during read");

    property p_write_bus;
        @(posedge clk) disable iff (srst)
        $fell(write_strobe_n) |-> data_lines_oe [*2] ##1 (write_strobe_n && data_lines_oe);
    endproperty
    a_write_bus: assert property (p_write_bus) else $error("write strobe without data");

    property p_poll;
        @(posedge clk) disable iff (srst)
        (branch_on_poll_low_instr && state == ST_RUN && !rst_s && !poll_s_n)
            |=> (branch_taken && program_counter == $past(branch_target));
    endproperty
    a_poll: assert property (p_poll) else $error("poll branch not taken");

    property p_release;
        @(posedge clk) disable iff (srst)
        (state == ST_RUN && $past(state) == ST_EXIT) |-> (data_read_strobe_n && !data_lines_oe);
    endproperty
    a_release: assert property (p_release) else $error("bus active before resume");
endmodule : dsp_reset_and_control_inputs

// *** test/ext_mem_model.sv ***
// external memory and peripheral stand-in on the data lines
`timescale 1ns/10ps
module ext_mem_model
    import dsp_ctl_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      data_read_strobe_n,
    input  wire logic                      instr_fetch_strobe_n,
    input  wire logic [dsp_ctl_pkg::ADDR_W-1:0] address_lines,
    output logic      [dsp_ctl_pkg::DATA_W-1:0] data_lines_in
);
    logic [DATA_W-1:0] last = 16'h0;  // last word put on the bus
    logic              drv;           // memory or port answering
    // answer only under a read or fetch strobe, so a stray capture shows
    assign drv = !data_read_strobe_n || !instr_fetch_strobe_n;
    always @(posedge clk)
        if (drv)
            last <= {4'h5, address_lines};
    // released bus shows the inverse of the last word, never a stale copy
    assign data_lines_in = drv ? {4'h5, address_lines} : ~last;
endmodule : ext_mem_model

// *** test/tb.sv ***
// self-checking bench for the reset and control block
`timescale 1ns/10ps
module tb;
    import dsp_ctl_pkg::*;
    logic clk = 1'h0, srst = 1'h1, reset_in_n = 1'h1, memory_config_select = 1'h0;
    logic branch_poll_in_n = 1'h1, interrupt_in_n = 1'h1, cmd_valid = 1'h0, branch_on_poll_low_instr = 1'h0;
    op_t  cmd_op = OP_NONE;
    logic [ADDR_W-1:0] cmd_addr = 12'h0, branch_target = 12'h0, address_lines, program_counter;
    logic [DATA_W-1:0] cmd_wdata = 16'h0, data_lines_in, data_lines_out, rdata;
    logic system_clock_out, data_read_strobe_n, write_strobe_n, instr_fetch_strobe_n, data_lines_oe;
    logic cmd_ready, rdata_valid, onchip_fetch, branch_taken, interrupt_req;
    logic [3:0] pins;  // read, write, fetch strobes and bus enable
    int n_errors = 0, total_checks = 0;
    assign pins = {data_read_strobe_n, write_strobe_n, instr_fetch_strobe_n, data_lines_oe};
    always #25 clk = ~clk;
    dsp_reset_and_control_inputs uut (.*);
    ext_mem_model mem (.*);
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // a wait that ran out ends the run at once
    task automatic bound_ok(input string nm, input logic ok);
        chk(nm, ok, 1'h1);
        if (!ok)
            stop_test();
    endtask : bound_ok
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    // request held until a strobe or the on-chip fetch flag shows, i.e. past the taking tick
    task automatic access(input op_t op, input logic [11:0] a);
        int i;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = 16'hc3a5;
        cmd_valid = 1'h1;
        for (i = 0; i < 12 && pins[3:1] === 3'h7 && onchip_fetch !== 1'h1; i++)
            step();
        cmd_valid = 1'h0;
        bound_ok("taken", i < 12);
    endtask : access
    task automatic xfer(input op_t op, input logic [11:0] a, input logic [11:0] ea, input logic [3:0] exp);
        int i;
        logic wr;  // write or port output, no read data expected
        wr = (op == OP_WRITE) || (op == OP_PORT_OUT);
        access(op, a);
        chk("pins", pins, exp);
        chk("addr", address_lines, ea);
        if (op == OP_FETCH)
            chk("pc", program_counter, ea + 12'h1);
        if (wr)
            chk("wdata", data_lines_out, 16'hc3a5);
        step();
        step();
        chk("width", pins[3:1], 3'h7);
        if (!wr)
        begin
            for (i = 0; i < 6 && rdata_valid !== 1'h1; i++)
                step();
            bound_ok("rvalid", i < 6);
            chk("rdata", rdata, {4'h5, ea});
        end
    endtask : xfer
    // two low master cycles out of every four, repeating
    task automatic sc_clock();
        logic [7:0] s;
        for (int i = 0; i < 8; i++)
        begin
            step();
            s[i] = system_clock_out;
        end
        chk("clk_rep", s[3:0], s[7:4]);
        chk("clk_duty", s[1:0], {~s[3:2]});
    endtask : sc_clock
    task automatic sc_branch(input logic poll, input logic [11:0] t);
        logic seen;
        seen = 1'h0;
        // poll changes just after a clock edge
        branch_poll_in_n = poll;
        branch_target = t;
        // poll held well past one cycle
        repeat (6) step();
        branch_on_poll_low_instr = 1'h1;
        step();
        branch_on_poll_low_instr = 1'h0;
        for (int i = 0; i < 4; i++)
        begin
            seen |= branch_taken;
            step();
        end
        chk("br_taken", seen, !poll);
        if (!poll)
            chk("br_pc", program_counter, t);
        branch_poll_in_n = 1'h1;
    endtask : sc_branch
    task automatic sc_reset();
        int i;
        // reset only while idle, no write is cut
        reset_in_n = 1'h0;
        repeat (8) step();
        chk("rst_pins", pins, 4'he);
        // held five internal cycles in all
        repeat (12) step();
        chk("rst_addr", address_lines, 12'h0);
        chk("rst_pc", program_counter, 12'h0);
        reset_in_n = 1'h1;
        for (i = 0; i < 16 && cmd_ready !== 1'h1; i++)
            step();
        bound_ok("rst_exit", i < 16);
        chk("rst_min", i >= 4, 1'h1);
        chk("rst_rel", pins, 4'he);
    endtask : sc_reset
    initial
    begin
        int i;
        repeat (20) step();
        srst = 1'h0;
        for (i = 0; i < 40 && cmd_ready !== 1'h1; i++)
            step();
        bound_ok("ready", i < 40);
        sc_clock();
        xfer(OP_WRITE, 12'h9a5, 12'h9a5, 4'hb);
        xfer(OP_READ, 12'h3c7, 12'h3c7, 4'h6);
        xfer(OP_PORT_OUT, 12'hffd, 12'h005, 4'hb);
        xfer(OP_PORT_IN, 12'h5fa, 12'h002, 4'h6);
        xfer(OP_FETCH, 12'h0, 12'h000, 4'hc);
        // on-chip mode: fetch with no strobe
        memory_config_select = 1'h1;
        repeat (4) step();
        access(OP_FETCH, 12'h0);
        step();
        chk("onchip", pins, 4'he);
        memory_config_select = 1'h0;
        repeat (8) step();
        sc_branch(1'h0, 12'h7e1);
        sc_branch(1'h1, 12'h123);
        interrupt_in_n = 1'h0;
        repeat (6) step();
        chk("irq", interrupt_req, 1'h1);
        interrupt_in_n = 1'h1;
        sc_reset();
        xfer(OP_FETCH, 12'h0, 12'h0, 4'hc);
        stop_test();
    end
endmodule : tb
